// ### core/prog_flow_pkg.sv
// Constants and types shared by the program flow logic
package prog_flow_pkg;
	localparam int PC_W = 13;
	localparam int SEG_W = 3;
	localparam int ADDR_W = 16;
	localparam int WORD_W = 16;
	localparam int OPC_W = 5;
	localparam int OPC_LSB = 11;
	localparam int PAGE_LSB = 11;
	localparam int STACK_DEPTH = 8;
	localparam logic [PC_W-1:0] RESET_PC = 13'h0000;
	localparam logic [SEG_W-1:0] RESET_SEG = 3'h0;
	// Direct jump opcodes 0CH..0FH: upper three bits fixed, low two are page
	localparam logic [2:0] JUMP_OP_HI = 3'h3;
	localparam logic [OPC_W-1:0] CALL_OP = 5'h1D;
	localparam logic [OPC_W-1:0] SYSTEM_ENTRY_OP = 5'h1E;
	localparam logic [OPC_W-1:0] MISC_OP = 5'h1F;
	// Sub-codes in the low nibble of the misc group
	localparam logic [3:0] SUBROUTINE_RETURN_OP = 4'h0;
	localparam logic [3:0] RETURN_WITH_SKIP_OP = 4'h1;
	localparam logic [3:0] JUMP_INDIRECT_OP = 4'h2;
	localparam logic [3:0] CALL_INDIRECT_OP = 4'h3;
	localparam logic [3:0] TABLE_READ_OP = 4'h4;
	// System entry operand: 3-bit block, 4-bit step
	localparam int SYS_BLOCK_LSB = 4;
	localparam int SYS_BLOCK_W = 3;
	localparam int SYS_STEP_W = 4;
	localparam int BLOCK_LSB = 8;
	localparam logic [SEG_W-1:0] SYSTEM_SEG = 3'h1;
	localparam logic [PC_W-1:0] INT_VECTOR_PC = 13'h0001;
	localparam logic [SEG_W-1:0] INT_VECTOR_SEG = 3'h0;
	typedef enum logic [0:0] {PH_FETCH, PH_TABLE} phase_t;
endpackage

// ### core/return_stack.sv
// Last-in first-out return address store
`timescale 1ns/10ps
module return_stack #(
	parameter int DEPTH = prog_flow_pkg::STACK_DEPTH,
	parameter int W = prog_flow_pkg::ADDR_W
) (
	input wire logic clk_sys, // System clock
	input wire logic reset, // Async reset, high
	input wire logic push, // Store pushData on top
	input wire logic pop, // Drop top entry
	input wire logic [W-1:0] pushData, // Address to save
	output logic [W-1:0] topData // Most recent entry
);
	import prog_flow_pkg::*;
	localparam int PTR_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PTR_W-1:0] count;
	} stk_t;
	stk_t st_r;
	stk_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (push && !pop && st_r.count != PTR_W'(DEPTH))
		begin
			st_nxt.mem[st_r.count] = pushData; // RULE24
			st_nxt.count = st_r.count + PTR_ONE;
		end
		else if (pop && !push && st_r.count != '0)
		begin
			st_nxt.count = st_r.count - PTR_ONE; // RULE24
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign topData = (st_r.count == '0) ? '0 : st_r.mem[st_r.count - PTR_ONE];

	a_push_pop_lifo: assert property (@(posedge clk_sys) disable iff (reset) // RULE24
		(push && !pop && st_r.count != PTR_W'(DEPTH)) |=> (topData == $past(pushData)))
		else $error("pushed address not on top");
endmodule // return_stack

// ### core/prog_flow.sv
// Next fetch address, branch, call, return and table read logic
`timescale 1ns/10ps

// =====================================================================
// Overview of operation
// RULE1: Store is array of 16-bit steps.
// RULE2: Pages are 2K steps, index above 11 bits.
// RULE3: Four pages form 13-bit segment.
// RULE4: System segment split into 256-step blocks.
// RULE5: Each instruction is one word, one fetch.
// RULE6: Table read copies word at pointer to buffer.
// RULE7: Program store is never written.
// RULE8: Start at 0000H after reset, then sequential.
// RULE9: Accepted interrupt loads fixed vector address.
// RULE10: Direct jump target is page bits plus operand.
// RULE11: Direct jump keeps segment bits.
// RULE12: Indirect jump takes pointer, may change segment.
// RULE13: Jump opcodes 0CH-0FH give pages 0-3.
// RULE14: Returns resume after the calling instruction.
// RULE15: Return with skip nulls next instruction.
// RULE16: Direct call targets page 0 by operand.
// RULE17: Calls and returns work from any page.
// RULE18: Direct call keeps segment bits.
// RULE19: Indirect call takes target from pointer.
// RULE20: System entry reaches system segment from anywhere.
// RULE21: Entry operand: 3-bit block, 4-bit step.
// RULE22: Pointer low 13 to counter, rest to segment.
// RULE23: Counter increments after each fetch.
// RULE24: Calls push, returns pop, last in first out.
module prog_flow #(
	parameter int PTR_SEG_BITS = prog_flow_pkg::SEG_W
) (
	input wire logic clk_sys, // System clock, 25 MHz
	input wire logic reset, // Async reset, high
	input wire logic execEnable, // Instruction cycle enable pulse
	input wire logic [prog_flow_pkg::WORD_W-1:0] instrWord, // Word read at romAddr
	input wire logic [prog_flow_pkg::ADDR_W-1:0] addressPointer, // Pointer register value
	input wire logic intRequest, // Enabled interrupt pending
	output logic [prog_flow_pkg::ADDR_W-1:0] romAddr, // Read address to store
	output logic intAck, // Interrupt taken this cycle
	output logic instrSuppress, // Treat current word as no-op
	output logic tableBusy, // Store port used by table read
	output logic [prog_flow_pkg::WORD_W-1:0] dataBufferRegister, // Table read result
	output logic dataBufferStrobe // Buffer loaded this cycle
);
	import prog_flow_pkg::*;

	// =================================================================
	// State
	typedef struct packed {
		phase_t phase;
		logic [SEG_W-1:0] seg;
		logic [PC_W-1:0] pc;
		logic skip;
		logic [ADDR_W-1:0] tableAddr;
		logic [WORD_W-1:0] dbf;
		logic dbfStrobe;
	} state_t;
	state_t st_r;
	state_t st_nxt;

	logic stackPush;
	logic stackPop;
	logic [ADDR_W-1:0] stackIn;
	logic [ADDR_W-1:0] stackTop;
	logic [OPC_W-1:0] opcode;
	logic [PAGE_LSB-1:0] operand;
	logic [SEG_W-1:0] segMask;
	localparam int SUB_W = $bits(SUBROUTINE_RETURN_OP);
	localparam int PAGE_W = PC_W - PAGE_LSB;
	logic [SUB_W-1:0] subCode;

	assign opcode = instrWord[WORD_W-1:OPC_LSB]; // RULE5
	assign operand = instrWord[PAGE_LSB-1:0];
	assign subCode = instrWord[SUB_W-1:0];
	assign segMask = SEG_W'((4'h1 << PTR_SEG_BITS) - 4'h1);

	// =================================================================
	// Helpers
	function automatic logic [PC_W-1:0] incPc(input logic [PC_W-1:0] pc);
		return PC_W'(pc + 13'h0001); // RULE23
	endfunction

	function automatic logic [ADDR_W-1:0] ptrTarget(input logic [ADDR_W-1:0] ptr,
		input logic [SEG_W-1:0] mask);
		return {ptr[ADDR_W-1:PC_W] & mask, ptr[PC_W-1:0]}; // RULE22
	endfunction

	function automatic logic [PC_W-1:0] sysTarget(input logic [PAGE_LSB-1:0] opnd);
		logic [PC_W-1:0] t;
		t = '0;
		t[BLOCK_LSB +: SYS_BLOCK_W] = opnd[SYS_BLOCK_LSB +: SYS_BLOCK_W]; // RULE4 RULE21
		t[SYS_STEP_W-1:0] = opnd[SYS_STEP_W-1:0];
		return t;
	endfunction

	// =================================================================
	// Next address selection
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.dbfStrobe = 1'b0;
		stackPush = 1'b0;
		stackPop = 1'b0;
		stackIn = {st_r.seg, incPc(st_r.pc)}; // RULE14 RULE17
		intAck = 1'b0;
		unique case (st_r.phase)
			PH_FETCH:
			begin
				if (execEnable)
				begin
					if (intRequest)
					begin
						stackPush = 1'b1;
						// Pending skip: return past the nulled word
						stackIn = {st_r.seg, st_r.skip ? incPc(st_r.pc) : st_r.pc}; // RULE15
						st_nxt.seg = INT_VECTOR_SEG; // RULE9
						st_nxt.pc = INT_VECTOR_PC;
						st_nxt.skip = 1'b0;
						intAck = 1'b1;
					end
					else if (st_r.skip)
					begin
						st_nxt.skip = 1'b0; // RULE15
						st_nxt.pc = incPc(st_r.pc);
					end
					else if (opcode[OPC_W-1:PAGE_W] == JUMP_OP_HI)
					begin
						st_nxt.pc = {opcode[PAGE_W-1:0], operand}; // RULE10 RULE11 RULE13 RULE3 RULE2
					end
					else if (opcode == CALL_OP)
					begin
						stackPush = 1'b1; // RULE24
						st_nxt.pc = {PAGE_W'(0), operand}; // RULE16 RULE18
					end
					else if (opcode == SYSTEM_ENTRY_OP)
					begin
						stackPush = 1'b1;
						st_nxt.seg = SYSTEM_SEG; // RULE20
						st_nxt.pc = sysTarget(operand);
					end
					else if (opcode == MISC_OP)
					begin
						st_nxt.pc = incPc(st_r.pc);
						unique case (subCode)
							SUBROUTINE_RETURN_OP, RETURN_WITH_SKIP_OP:
							begin
								stackPop = 1'b1;
								{st_nxt.seg, st_nxt.pc} = stackTop; // RULE14
								st_nxt.skip = (subCode == RETURN_WITH_SKIP_OP); // RULE15
							end
							JUMP_INDIRECT_OP:
							begin
								{st_nxt.seg, st_nxt.pc} = ptrTarget(addressPointer, segMask); // RULE12
							end
							CALL_INDIRECT_OP:
							begin
								stackPush = 1'b1;
								{st_nxt.seg, st_nxt.pc} = ptrTarget(addressPointer, segMask); // RULE19
							end
							TABLE_READ_OP:
							begin
								st_nxt.tableAddr = ptrTarget(addressPointer, segMask); // RULE6
								st_nxt.phase = PH_TABLE;
							end
							default:
							begin
								st_nxt.pc = incPc(st_r.pc);
							end
						endcase
					end
					else
					begin
						st_nxt.pc = incPc(st_r.pc); // RULE8 RULE23
					end
				end
			end
			PH_TABLE:
			begin
				st_nxt.dbf = instrWord; // RULE6
				st_nxt.dbfStrobe = 1'b1;
				st_nxt.phase = PH_FETCH;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			st_r <= '0;
			st_r.phase <= PH_FETCH;
			st_r.pc <= RESET_PC; // RULE8
			st_r.seg <= RESET_SEG;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// =================================================================
	// Return stack
	return_stack #(
		.DEPTH(STACK_DEPTH),
		.W(ADDR_W)
	) u_stack (
		.clk_sys(clk_sys),
		.reset(reset),
		.push(stackPush),
		.pop(stackPop),
		.pushData(stackIn),
		.topData(stackTop)
	);

	// =================================================================
	// Outputs; store is only ever addressed, never written
	assign romAddr = (st_r.phase == PH_TABLE) ? st_r.tableAddr : {st_r.seg, st_r.pc}; // RULE1 RULE7
	assign tableBusy = (st_r.phase == PH_TABLE);
	assign instrSuppress = st_r.skip || intRequest;
	assign dataBufferRegister = st_r.dbf;
	assign dataBufferStrobe = st_r.dbfStrobe;

	// =================================================================
	// Checks
	a_seq_increment: assert property (@(posedge clk_sys) disable iff (reset) // RULE23
		(execEnable && st_r.phase == PH_FETCH && !intRequest && !st_r.skip
		&& opcode[OPC_W-1:2] != JUMP_OP_HI && opcode != CALL_OP
		&& opcode != SYSTEM_ENTRY_OP && opcode != MISC_OP)
		|=> (st_r.pc == $past(st_r.pc) + 13'h0001 && st_r.seg == $past(st_r.seg)))
		else $error("sequential fetch did not advance by one");

	a_jump_direct: assert property (@(posedge clk_sys) disable iff (reset) // RULE10
		(execEnable && st_r.phase == PH_FETCH && !intRequest && !st_r.skip
		&& opcode[OPC_W-1:2] == JUMP_OP_HI)
		|=> (romAddr == {$past(st_r.seg), $past(instrWord[12:0])}))
		else $error("direct jump target or segment wrong");

	a_call_page0: assert property (@(posedge clk_sys) disable iff (reset) // RULE16
		(execEnable && st_r.phase == PH_FETCH && !intRequest && !st_r.skip && opcode == CALL_OP)
		|=> (st_r.pc[PC_W-1:PAGE_LSB] == 2'b00 && st_r.seg == $past(st_r.seg)))
		else $error("direct call left page 0 or segment");

	a_call_return: assert property (@(posedge clk_sys) disable iff (reset) // RULE14
		(execEnable && st_r.phase == PH_FETCH && !intRequest && !st_r.skip && opcode == CALL_OP)
		|=> (stackTop == {$past(st_r.seg), $past(st_r.pc) + 13'h0001}))
		else $error("return address not saved");

	a_sys_entry: assert property (@(posedge clk_sys) disable iff (reset) // RULE21
		(execEnable && st_r.phase == PH_FETCH && !intRequest && !st_r.skip
		&& opcode == SYSTEM_ENTRY_OP)
		|=> (st_r.seg == SYSTEM_SEG && st_r.pc[7:4] == 4'h0 && st_r.pc[PC_W-1:PAGE_LSB] == 2'b00
		&& st_r.pc[10:8] == $past(instrWord[6:4]) && st_r.pc[3:0] == $past(instrWord[3:0])))
		else $error("system entry target wrong");

	a_skip_after: assert property (@(posedge clk_sys) disable iff (reset) // RULE15
		(execEnable && st_r.phase == PH_FETCH && !intRequest && !st_r.skip
		&& opcode == MISC_OP && instrWord[3:0] == RETURN_WITH_SKIP_OP)
		|=> (instrSuppress && romAddr == $past(stackTop)))
		else $error("return with skip did not null next word");

	a_table_read: assert property (@(posedge clk_sys) disable iff (reset) // RULE6
		(st_r.phase == PH_TABLE)
		|=> (dataBufferStrobe && dataBufferRegister == $past(instrWord) && !tableBusy))
		else $error("table word not loaded into buffer");

	a_int_vector: assert property (@(posedge clk_sys) disable iff (reset) // RULE9
		intAck |=> (romAddr == {INT_VECTOR_SEG, INT_VECTOR_PC}))
		else $error("interrupt vector not loaded");

	a_indirect_seg: assert property (@(posedge clk_sys) disable iff (reset) // RULE22
		(execEnable && st_r.phase == PH_FETCH && !intRequest && !st_r.skip
		&& opcode == MISC_OP && instrWord[3:0] == JUMP_INDIRECT_OP)
		|=> (st_r.pc == $past(addressPointer[12:0])
		&& st_r.seg == ($past(addressPointer[15:13]) & segMask)))
		else $error("indirect jump target wrong");

	a_reset_start: assert property (@(posedge clk_sys) // RULE8
		reset |-> (romAddr == {RESET_SEG, RESET_PC} && !dataBufferStrobe))
		else $error("reset address not zero");

	a_call_indirect: assert property (@(posedge clk_sys) disable iff (reset) // RULE19
		(execEnable && st_r.phase == PH_FETCH && !intRequest && !st_r.skip
		&& opcode == MISC_OP && subCode == CALL_INDIRECT_OP)
		|=> (romAddr == ptrTarget($past(addressPointer), segMask)
		&& stackTop == {$past(st_r.seg), $past(st_r.pc) + 13'h0001}))
		else $error("indirect call target or return address wrong");

	a_return_pop: assert property (@(posedge clk_sys) disable iff (reset) // RULE24
		(execEnable && st_r.phase == PH_FETCH && !intRequest && !st_r.skip
		&& opcode == MISC_OP && subCode == SUBROUTINE_RETURN_OP)
		|=> (romAddr == $past(stackTop) && !st_r.skip))
		else $error("return did not resume at saved address");

	a_skip_nulls: assert property (@(posedge clk_sys) disable iff (reset) // RULE15
		(execEnable && st_r.phase == PH_FETCH && !intRequest && st_r.skip)
		|=> (st_r.pc == $past(st_r.pc) + 13'h0001 && st_r.seg == $past(st_r.seg) && !st_r.skip))
		else $error("skipped word was executed");

	a_table_addr: assert property (@(posedge clk_sys) disable iff (reset) // RULE6
		(execEnable && st_r.phase == PH_FETCH && !intRequest && !st_r.skip
		&& opcode == MISC_OP && subCode == TABLE_READ_OP)
		|=> (tableBusy && romAddr == ptrTarget($past(addressPointer), segMask)))
		else $error("table read address wrong");

	a_int_push: assert property (@(posedge clk_sys) disable iff (reset) // RULE24
		(intAck && !st_r.skip) |=> (stackTop == $past(romAddr)))
		else $error("interrupted address not saved");
endmodule // prog_flow

// ### sim/rom_model.sv
// Read-only program store model seen by the program flow logic
`timescale 1ns/10ps
module rom_model (
	input wire logic [prog_flow_pkg::ADDR_W-1:0] romAddr, // Read address
	output logic [prog_flow_pkg::WORD_W-1:0] instrWord // Word at romAddr
);
	import prog_flow_pkg::*;
	// =====
	// Storage, one 16-bit word per step
	logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
	initial
	begin
		for (int i = 0; i < (1 << ADDR_W); i++)
		begin
			mem[i] = 16'h0000;
		end
	end
	// No write port: only the bench preloads contents
	assign instrWord = mem[romAddr];
endmodule // rom_model

// ### sim/prog_flow_tb.sv
// Self-checking bench for the program flow logic
`timescale 1ns/10ps
module prog_flow_tb;
	import prog_flow_pkg::*;
	logic clk_sys;
	logic reset;
	logic execEnable;
	logic intRequest;
	logic [ADDR_W-1:0] addressPointer;
	logic [WORD_W-1:0] instrWord;
	logic [ADDR_W-1:0] romAddr;
	logic intAck;
	logic instrSuppress;
	logic tableBusy;
	logic [WORD_W-1:0] dataBufferRegister;
	logic dataBufferStrobe;
	logic [ADDR_W-1:0] a1;
	logic [ADDR_W-1:0] a2;
	int nMismatch = 0;
	int cmpCount = 0;

	prog_flow dut (
		.clk_sys(clk_sys),
		.reset(reset),
		.execEnable(execEnable),
		.instrWord(instrWord),
		.addressPointer(addressPointer),
		.intRequest(intRequest),
		.romAddr(romAddr),
		.intAck(intAck),
		.instrSuppress(instrSuppress),
		.tableBusy(tableBusy),
		.dataBufferRegister(dataBufferRegister),
		.dataBufferStrobe(dataBufferStrobe)
	);
	rom_model rom (
		.romAddr(romAddr),
		.instrWord(instrWord)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// =====
	// Shared tasks
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmpCount++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("ERROR %0t: seen %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmpCount, nMismatch);
		if (nMismatch == 0 && cmpCount > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Place a word at the current address and execute it
	task automatic step(input logic [15:0] w);
		rom.mem[romAddr] = w;
		execEnable = 1'b1;
		@(posedge clk_sys);
		#1;
	endtask

	function automatic logic [15:0] mw(input logic [3:0] sub);
		return {MISC_OP, 7'h00, sub};
	endfunction

	// =====
	// Scenarios
	task automatic t_seq();
		check(romAddr, 16'h0000);
		reset = 1'b0;
		for (int i = 1; i < 4; i++)
		begin
			step(16'h0000);
			check(romAddr, 16'(i));
		end
		// Undecoded misc sub-code just advances
		step(mw(4'hF));
		check(romAddr, 16'h0004);
	endtask

	task automatic t_jump();
		addressPointer = 16'h4123;
		step(mw(JUMP_INDIRECT_OP));
		check(romAddr, 16'h4123);
		for (logic [2:0] p = 3'h0; p < 3'h4; p++)
		begin
			step({JUMP_OP_HI, p[1:0], 11'h110});
			check(romAddr, {3'h2, p[1:0], 11'h110});
		end
	endtask

	task automatic t_call();
		a1 = romAddr;
		step({CALL_OP, 11'h055});
		check(romAddr, {3'h2, 2'b00, 11'h055});
		a2 = romAddr;
		addressPointer = 16'h6ABC;
		step(mw(CALL_INDIRECT_OP));
		check(romAddr, 16'h6ABC);
		step(mw(SUBROUTINE_RETURN_OP));
		check(romAddr, a2 + 16'h0001);
		check({15'h0000, instrSuppress}, 16'h0000);
		step(mw(RETURN_WITH_SKIP_OP));
		check(romAddr, a1 + 16'h0001);
		check({15'h0000, instrSuppress}, 16'h0001);
		step({JUMP_OP_HI, 2'b00, 11'h000});
		check(romAddr, a1 + 16'h0002);
	endtask

	task automatic t_sys();
		a1 = romAddr;
		step({SYSTEM_ENTRY_OP, 4'h0, 7'h1E});
		check(romAddr, {SYSTEM_SEG, 13'h010E});
		step(mw(SUBROUTINE_RETURN_OP));
		check(romAddr, a1 + 16'h0001);
		step({SYSTEM_ENTRY_OP, 4'h0, 7'h7F});
		check(romAddr, {SYSTEM_SEG, 13'h070F});
		step(mw(SUBROUTINE_RETURN_OP));
		check(romAddr, a1 + 16'h0002);
	endtask

	task automatic t_table();
		a1 = romAddr;
		addressPointer = 16'h2040;
		rom.mem[16'h2040] = 16'hA5C3;
		step(mw(TABLE_READ_OP));
		// No request while the table word is read
		execEnable = 1'b0;
		check({15'h0000, tableBusy}, 16'h0001);
		check(romAddr, 16'h2040);
		@(posedge clk_sys);
		#1;
		check({15'h0000, dataBufferStrobe}, 16'h0001);
		check(dataBufferRegister, 16'hA5C3);
		check(romAddr, a1 + 16'h0001);
		check(rom.mem[16'h2040], 16'hA5C3);
	endtask

	task automatic t_int();
		a1 = romAddr;
		rom.mem[a1] = {JUMP_OP_HI, 2'b11, 11'h7FF};
		execEnable = 1'b1;
		intRequest = 1'b1;
		#5;
		check({15'h0000, intAck}, 16'h0001);
		check({15'h0000, instrSuppress}, 16'h0001);
		@(posedge clk_sys);
		#1;
		intRequest = 1'b0;
		check(romAddr, {INT_VECTOR_SEG, INT_VECTOR_PC});
		step(mw(SUBROUTINE_RETURN_OP));
		check(romAddr, a1);
		check({15'h0000, intAck}, 16'h0000);
		step(rom.mem[a1]);
		check(romAddr, {a1[15:13], 2'b11, 11'h7FF});
	endtask

	// =====
	// Main sequence and watchdog
	initial
	begin
		reset = 1'b1;
		execEnable = 1'b0;
		intRequest = 1'b0;
		addressPointer = 16'h0000;
		repeat (5) @(posedge clk_sys);
		#1;
		t_seq();
		t_jump();
		t_call();
		t_sys();
		t_table();
		t_int();
		execEnable = 1'b0;
		summarize();
	end

	initial
	begin
		repeat (2000) @(posedge clk_sys);
		nMismatch++;
		$display("ERROR %0t: run did not finish", $time);
		summarize();
	end
endmodule // prog_flow_tb
